// ---- logic/i2c_io_expander.sv ----
// Summary of operation
// - command byte after address sets register pointer
// - codes 0..7 select the eight registers
// - input registers show sampled pin levels
// - writes to input registers are discarded
// - output bits only reach output-configured pins
// - output register reads return stored bits
// - invert bit one flips returned input bit
// - direction one is input, zero output
// - defaults make every pin an input
// - power-on reset restores registers and engine
// - full variant holds registers and engine while pin low
// - bus-only variant resets just serial engine
// - output pins driven high or low
// - pointer alternates within pair after each byte
// - any number of bytes per transfer
// - reads after repeated start alternate until nack
`include "io_expander_defs.svh"

module i2c_io_expander #(
	parameter bit FULL_RESET = 1'h1,
	parameter logic [4:0] ADDR_PREFIX = `ADDR_PREFIX_DEF
) (
	// system clock and power-on reset
	input wire logic clock,
	input wire logic arst_n,
	// serial link, link clock domain
	input wire logic link_clock,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// strap and reset pins
	input wire logic [1:0] addr_strap,
	input wire logic reset_pin_n,
	// sixteen port pins, port 1 in the upper byte
	input wire logic [15:0] io_i,
	output logic [15:0] io_o,
	output logic [15:0] io_oe_n
);

	// ************************************************************
	// helper functions
	// ************************************************************

	// input registers take no writes
	function automatic logic is_input(input logic [2:0] idx);
		return idx[2:1] == 2'h0;
	endfunction

	// replace one byte of a port pair word
	function automatic logic [15:0] put_byte(input logic [15:0] w,
			input logic hi, input logic [7:0] d);
		return hi ? {d, w[7:0]} : {w[15:8], d};
	endfunction

	// ************************************************************
	// core domain: reset, synchronisers
	// ************************************************************
	logic rst_s1_r, srst_n; // reset release stages
	logic pin_s1_r, pin_s2_r; // reset pin sync
	logic [15:0] in_s1_r, in_s2_r; // pin level sync
	logic req_s1_r, req_s2_r, req_seen_r; // request toggle sync
	logic ack_tgl_r; // answer toggle
	logic [7:0] rdata_r; // answer byte, held until next
	logic [15:0] out_r, inv_r, dir_r; // port pair registers
	io_expander_pkg::reg_req_t req_r; // link-side request word
	logic req_tgl_r; // link-side request toggle

	// power-on reset release through two flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'h0;
			srst_n <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			srst_n <= rst_s1_r;
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			pin_s1_r <= 1'h1;
			pin_s2_r <= 1'h1;
			in_s1_r <= 16'h0000;
			in_s2_r <= 16'h0000;
			req_s1_r <= 1'h0;
			req_s2_r <= 1'h0;
			req_seen_r <= 1'h0;
		end else begin
			pin_s1_r <= reset_pin_n;
			pin_s2_r <= pin_s1_r;
			in_s1_r <= io_i;
			in_s2_r <= in_s1_r;
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			req_seen_r <= req_s2_r;
		end
	end

	// ************************************************************
	// core domain: decode and selection
	// ************************************************************
	wire do_op = req_s2_r != req_seen_r; // request word is stable here
	wire pin_low = !pin_s2_r;
	wire hold_regs = FULL_RESET && pin_low;
	wire do_wr = do_op && req_r.wr && !is_input(req_r.idx);
	wire hi = req_r.idx[0];
	// polarity applied on the read path only
	wire [15:0] in_view = in_s2_r ^ inv_r;
	// pair select by upper index bits
	wire [15:0] sel_word = (req_r.idx[2:1] == 2'h0) ? in_view :
		(req_r.idx[2:1] == 2'h1) ? out_r :
		(req_r.idx[2:1] == 2'h2) ? inv_r : dir_r;
	wire [7:0] sel_byte = hi ? sel_word[15:8] : sel_word[7:0];
	wire wr_out = do_wr && req_r.idx[2:1] == 2'h1;
	wire wr_inv = do_wr && req_r.idx[2:1] == 2'h2;
	wire wr_dir = do_wr && req_r.idx[2:1] == 2'h3;

	// ************************************************************
	// core domain: register file
	// ************************************************************

	// full variant holds defaults while pin low
	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			out_r <= `RST_OUTPUT_DRIVE;
			inv_r <= `RST_INPUT_INVERT;
			dir_r <= `RST_DIRECTION;
		end else if (hold_regs) begin
			out_r <= `RST_OUTPUT_DRIVE;
			inv_r <= `RST_INPUT_INVERT;
			dir_r <= `RST_DIRECTION;
		end else begin
			if (wr_out) out_r <= put_byte(out_r, hi, req_r.data);
			if (wr_inv) inv_r <= put_byte(inv_r, hi, req_r.data);
			if (wr_dir) dir_r <= put_byte(dir_r, hi, req_r.data);
		end
	end

	// answer every request, read or write, with a toggle
	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			rdata_r <= 8'h00;
			ack_tgl_r <= 1'h0;
		end else if (do_op) begin
			rdata_r <= sel_byte;
			ack_tgl_r <= !ack_tgl_r;
		end
	end

	// enable low only on output pins
	assign io_o = out_r;
	assign io_oe_n = dir_r;

	// ************************************************************
	// link domain: reset and synchronisers
	// ************************************************************
	logic lrst_s1_r, lrst_n; // link reset release
	logic scl_s1_r, scl_s2_r, scl_p_r; // clock line sync
	logic sda_s1_r, sda_s2_r, sda_p_r; // data line sync
	logic lpin_s1_r, lpin_s2_r; // reset pin sync
	logic [1:0] strap_s1_r, strap_s2_r; // strap sync
	logic ack_s1_r, ack_s2_r, ack_seen_r; // answer toggle sync

	always_ff @(posedge link_clock or negedge arst_n) begin
		if (!arst_n) begin
			lrst_s1_r <= 1'h0;
			lrst_n <= 1'h0;
		end else begin
			lrst_s1_r <= 1'h1;
			lrst_n <= lrst_s1_r;
		end
	end

	// lines idle high, so line synchronisers reset high
	always_ff @(posedge link_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			{scl_s1_r, scl_s2_r, scl_p_r} <= 3'h7;
			{sda_s1_r, sda_s2_r, sda_p_r} <= 3'h7;
			{lpin_s1_r, lpin_s2_r} <= 2'h3;
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
			{ack_s1_r, ack_s2_r, ack_seen_r} <= 3'h0;
		end else begin
			{scl_s1_r, scl_s2_r, scl_p_r} <= {scl_i, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_p_r} <= {sda_i, sda_s1_r, sda_s2_r};
			{lpin_s1_r, lpin_s2_r} <= {reset_pin_n, lpin_s1_r};
			strap_s1_r <= addr_strap;
			strap_s2_r <= strap_s1_r;
			{ack_s1_r, ack_s2_r, ack_seen_r} <= {ack_tgl_r, ack_s1_r,
				ack_s2_r};
		end
	end

	// ************************************************************
	// link domain: line events
	// ************************************************************
	wire scl_high = scl_s2_r && scl_p_r;
	wire start_det = scl_high && sda_p_r && !sda_s2_r;
	wire stop_det = scl_high && !sda_p_r && sda_s2_r;
	wire scl_rise = scl_s2_r && !scl_p_r;
	wire scl_fall = !scl_s2_r && scl_p_r;
	wire ack_new = ack_s2_r != ack_seen_r;
	// pin resets the engine in both variants
	wire eng_clr = !lpin_s2_r;

	// ************************************************************
	// link domain: serial engine
	// ************************************************************
	io_expander_pkg::eng_state_t state_r, after_ack_r;
	logic [7:0] sr_r; // shift register
	logic [2:0] cnt_r; // bit counter
	logic got_r; // eighth bit taken
	logic [2:0] ptr_r; // register pointer
	logic sda_oe_n_r, sda_o_r; // open-drain driver

	wire [7:0] own_addr = {ADDR_PREFIX, strap_s2_r, 1'h0};
	// seven address bits must all match
	wire addr_ok = sr_r[7:1] == own_addr[7:1];
	wire byte_end = scl_fall && got_r;
	wire wr_fire = state_r == io_expander_pkg::ST_WDATA && byte_end;
	wire addr_fire = state_r == io_expander_pkg::ST_ADDR && byte_end;

	always_ff @(posedge link_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			state_r <= io_expander_pkg::ST_IDLE;
			after_ack_r <= io_expander_pkg::ST_IDLE;
			sr_r <= 8'h00;
			cnt_r <= 3'h0;
			got_r <= 1'h0;
			ptr_r <= 3'h0;
			sda_oe_n_r <= 1'h1;
			sda_o_r <= 1'h0;
			req_r <= '0;
			req_tgl_r <= 1'h0;
		end else if (eng_clr) begin
			// state machine only, pending toggle kept
			state_r <= io_expander_pkg::ST_IDLE;
			cnt_r <= 3'h0;
			got_r <= 1'h0;
			ptr_r <= 3'h0;
			sda_oe_n_r <= 1'h1;
		end else if (start_det) begin
			// also a repeated start mid-transfer
			state_r <= io_expander_pkg::ST_ADDR;
			cnt_r <= 3'h0;
			got_r <= 1'h0;
			sda_oe_n_r <= 1'h1;
		end else if (stop_det) begin
			state_r <= io_expander_pkg::ST_IDLE;
			sda_oe_n_r <= 1'h1;
		end else begin
			unique case (state_r)
			io_expander_pkg::ST_IDLE: begin
				sda_oe_n_r <= 1'h1;
			end
			io_expander_pkg::ST_ADDR, io_expander_pkg::ST_CMD,
			io_expander_pkg::ST_WDATA: begin
				if (scl_rise) begin
					sr_r <= {sr_r[6:0], sda_s2_r};
					cnt_r <= cnt_r + 3'h1;
					got_r <= cnt_r == `LAST_BIT_CNT;
				end else if (byte_end) begin
					got_r <= 1'h0;
					cnt_r <= 3'h0;
					sda_oe_n_r <= 1'h0;
					state_r <= io_expander_pkg::ST_ACK;
					if (addr_fire) begin
						// foreign address: stay off the line
						if (!addr_ok) begin
							sda_oe_n_r <= 1'h1;
							state_r <= io_expander_pkg::ST_IDLE;
						end
						// read bit goes to data out
						after_ack_r <= sr_r[`ADDR_RW_BIT] ?
							io_expander_pkg::ST_LOAD :
							io_expander_pkg::ST_CMD;
					end else if (state_r == io_expander_pkg::ST_CMD) begin
						ptr_r <= sr_r[`CMD_IDX_MSB:0];
						after_ack_r <= io_expander_pkg::ST_WDATA;
					end else begin
						// store, then other half of pair
						req_r <= '{wr: 1'h1, idx: ptr_r, data: sr_r};
						req_tgl_r <= !req_tgl_r;
						ptr_r <= {ptr_r[2:1], !ptr_r[0]};
						after_ack_r <= io_expander_pkg::ST_WDATA;
					end
				end
			end
			io_expander_pkg::ST_ACK: begin
				if (scl_fall) begin
					sda_oe_n_r <= 1'h1;
					state_r <= after_ack_r;
					if (after_ack_r == io_expander_pkg::ST_LOAD) begin
						req_r <= '{wr: 1'h0, idx: ptr_r, data: 8'h00};
						req_tgl_r <= !req_tgl_r;
					end
				end
			end
			io_expander_pkg::ST_LOAD: begin
				// scl low: drive first bit once data is back
				if (ack_new) begin
					sr_r <= rdata_r;
					sda_oe_n_r <= rdata_r[7];
					cnt_r <= 3'h0;
					state_r <= io_expander_pkg::ST_RDATA;
				end
			end
			io_expander_pkg::ST_RDATA: begin
				if (scl_fall) begin
					if (cnt_r == `LAST_BIT_CNT) begin
						sda_oe_n_r <= 1'h1;
						state_r <= io_expander_pkg::ST_RACK;
					end else begin
						sr_r <= {sr_r[6:0], 1'h0};
						sda_oe_n_r <= sr_r[6];
						cnt_r <= cnt_r + 3'h1;
					end
				end
			end
			io_expander_pkg::ST_RACK: begin
				if (scl_rise) begin
					if (sda_s2_r) begin
						state_r <= io_expander_pkg::ST_IDLE;
					end else begin
						ptr_r <= {ptr_r[2:1], !ptr_r[0]};
						state_r <= io_expander_pkg::ST_RACK2;
					end
				end
			end
			io_expander_pkg::ST_RACK2: begin
				if (scl_fall) begin
					req_r <= '{wr: 1'h0, idx: ptr_r, data: 8'h00};
					req_tgl_r <= !req_tgl_r;
					state_r <= io_expander_pkg::ST_LOAD;
				end
			end
			default: begin
				state_r <= io_expander_pkg::ST_IDLE;
				sda_oe_n_r <= 1'h1;
			end
			endcase
		end
	end

	assign sda_o = sda_o_r;
	assign sda_oe_n = sda_oe_n_r;

	// ************************************************************
	// checks, core domain
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!srst_n);

	a_input_discard: assert property (
		do_op && req_r.wr && is_input(req_r.idx) && !hold_regs
		|=> $stable(out_r) && $stable(inv_r) && $stable(dir_r))
		else $error("input register write changed state");
	a_output_store: assert property (
		wr_out && !hold_regs && !hi
		|=> out_r[7:0] == $past(req_r.data) && io_o == out_r)
		else $error("output register write not stored");
	a_read_invert: assert property (
		do_op && !req_r.wr && req_r.idx == `IDX_INPUT_LEVEL_PORT0
		|=> rdata_r == $past(in_s2_r[7:0] ^ inv_r[7:0]))
		else $error("input read ignores inversion");
	a_read_stored: assert property (
		do_op && !req_r.wr && req_r.idx == `IDX_OUTPUT_DRIVE_PORT1
		|=> rdata_r == $past(out_r[15:8]))
		else $error("output read not from flip-flops");
	a_full_reset: assert property (
		hold_regs |=> dir_r == `RST_DIRECTION && io_oe_n == 16'hFFFF
		&& out_r == `RST_OUTPUT_DRIVE)
		else $error("pin reset did not restore defaults");
	a_busonly_keep: assert property (
		!FULL_RESET && pin_low && !do_op |=> $stable(dir_r)
		&& $stable(out_r))
		else $error("bus-only reset disturbed registers");
	a_answer_toggle: assert property (
		do_op |=> ack_tgl_r != $past(ack_tgl_r) ##1 !do_op)
		else $error("request not answered once");

	// ************************************************************
	// checks, link domain
	// ************************************************************
	a_pair_toggle: assert property (@(posedge link_clock)
		disable iff (!lrst_n)
		wr_fire && !eng_clr && !start_det && !stop_det
		|=> ptr_r == {$past(ptr_r[2:1]), !$past(ptr_r[0])})
		else $error("pointer did not alternate in pair");
	a_addr_ignore: assert property (@(posedge link_clock)
		disable iff (!lrst_n)
		addr_fire && !addr_ok && !eng_clr && !start_det && !stop_det
		|=> (state_r == io_expander_pkg::ST_IDLE && sda_oe_n_r) [*2])
		else $error("foreign address acknowledged");

	c_write_out: cover property (wr_out ##1 !pin_low);
	c_read_in: cover property (do_op && !req_r.wr && is_input(req_r.idx));
	c_nack_end: cover property (@(posedge link_clock)
		state_r == io_expander_pkg::ST_RACK && scl_rise && sda_s2_r);

endmodule

// ---- common/io_expander_defs.svh ----
`ifndef IO_EXPANDER_DEFS_SVH
`define IO_EXPANDER_DEFS_SVH

// ************************************************************
// register indices selected by the command byte
// ************************************************************
`define IDX_INPUT_LEVEL_PORT0 3'h0
`define IDX_INPUT_LEVEL_PORT1 3'h1
`define IDX_OUTPUT_DRIVE_PORT0 3'h2
`define IDX_OUTPUT_DRIVE_PORT1 3'h3
`define IDX_INPUT_INVERT_PORT0 3'h4
`define IDX_INPUT_INVERT_PORT1 3'h5
`define IDX_DIRECTION_PORT0 3'h6
`define IDX_DIRECTION_PORT1 3'h7

// ************************************************************
// field layout of the command byte and address byte
// ************************************************************
`define CMD_IDX_MSB 2
`define ADDR_RW_BIT 0

// ************************************************************
// reset values, both ports packed as one 16-bit word
// ************************************************************
`define RST_OUTPUT_DRIVE 16'hFFFF
`define RST_INPUT_INVERT 16'h0000
`define RST_DIRECTION 16'hFFFF

// ************************************************************
// address prefix (arbitrary value) and byte bit count
// ************************************************************
`define ADDR_PREFIX_DEF 5'h1D
`define LAST_BIT_CNT 3'h7

`endif

// ---- common/io_expander_pkg.sv ----
package io_expander_pkg;

	// serial engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK = 4'h2,
		ST_CMD = 4'h3,
		ST_WDATA = 4'h4,
		ST_LOAD = 4'h5,
		ST_RDATA = 4'h6,
		ST_RACK = 4'h7,
		ST_RACK2 = 4'h8
	} eng_state_t;

	// one register access passed from link to core domain
	typedef struct packed {
		logic wr;
		logic [2:0] idx;
		logic [7:0] data;
	} reg_req_t;

endpackage

// ---- testbench/i2c_master_model.sv ----
// ************************************************************
// serial bus master on the far side of the expander
// ************************************************************
module i2c_master_model (
	// serial bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus: clock high and data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// one clock pulse; data moves only while the clock is low
	// low time kept at 1 us, since the device never stretches
	task automatic xfer(input logic b, output logic r);
		#250 sda_low = ~b;
		#750 scl = 1'b1;
		#350 r = sda;
		#350 scl = 1'b0;
	endtask

	// start, also used as repeated start
	task automatic start();
		#250 sda_low = 1'b0;
		#750 scl = 1'b1;
		#500 sda_low = 1'b1;
		#500 scl = 1'b0;
	endtask

	// stop; the clock then stands high until the next frame
	task automatic stop();
		#250 sda_low = 1'b1;
		#750 scl = 1'b1;
		#500 sda_low = 1'b0;
		#500;
	endtask

	// eight bits msb first, then sample the acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			xfer(b[i], ack);
		end
		xfer(1'b1, ack);
	endtask

	// read a byte, acknowledge all but the last
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, d[i]);
		end
		xfer(last, r);
	endtask
endmodule

// ---- testbench/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// prefix handed to both devices (arbitrary value)
	localparam logic [4:0] PFX = 5'h1D;

	// ************************************************************
	// clocks, pins and bus wires
	// ************************************************************
	logic clock = 1'b0;
	logic link_clock = 1'b0;
	logic arst_n = 1'b0;
	logic reset_pin_n = 1'b1;
	logic [1:0] strap = 2'h0;
	logic [15:0] io_i = 16'h0000;
	logic scl;
	logic m_low; // master pulls data low
	logic [1:0] oe_n; // device data enables
	logic [15:0] a_o, a_oe_n, b_o, b_oe_n;
	logic [1:0] sdo; // data drive values, open drain so never high
	// open-drain data line with pull-up
	wire logic sda = ~m_low & (&oe_n);
	wire logic [6:0] adr_a = {PFX, strap};
	wire logic [6:0] adr_b = {PFX, ~strap};
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int k;
	logic [7:0] ex [8]; // expected registers of device a
	logic [7:0] r0, r1;
	logic ack;

	// system clock 50 MHz, link clock 48 ns, phases unrelated
	always #10 clock = ~clock;
	initial begin
		#7;
		forever #24 link_clock = ~link_clock;
	end

	// ************************************************************
	// devices: full reset variant and bus-only variant
	// ************************************************************
	// both reset variants side by side
	i2c_io_expander #(.FULL_RESET(1'h1), .ADDR_PREFIX(PFX))
	u_i2c_io_expander (.clock(clock), .arst_n(arst_n),
		.link_clock(link_clock), .scl_i(scl), .sda_i(sda),
		.sda_o(sdo[0]), .sda_oe_n(oe_n[0]), .addr_strap(strap),
		.reset_pin_n(reset_pin_n), .io_i(io_i), .io_o(a_o),
		.io_oe_n(a_oe_n));
	i2c_io_expander #(.FULL_RESET(1'h0), .ADDR_PREFIX(PFX))
	u_i2c_io_expander_bus_only (.clock(clock), .arst_n(arst_n),
		.link_clock(link_clock), .scl_i(scl), .sda_i(sda),
		.sda_o(sdo[1]), .sda_oe_n(oe_n[1]), .addr_strap(~strap),
		.reset_pin_n(reset_pin_n), .io_i(io_i), .io_o(b_o),
		.io_oe_n(b_oe_n));
	i2c_master_model u_i2c_master_model (.scl(scl), .sda_low(m_low),
		.sda(sda));

	// ************************************************************
	// compares, expectations and bus tasks
	// ************************************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pins(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// input read: pin level flipped by the invert bits
	function automatic logic [7:0] exp_rd(input int p);
		return io_i[8*p +: 8] ^ ex[p+4];
	endfunction

	// one byte that the addressed device must acknowledge
	task automatic send(input logic [7:0] b);
		u_i2c_master_model.wbyte(b, ack);
		chk_byte({7'h00, ack}, 8'h00);
	endtask

	// write n bytes from d, low byte first, tracking the pointer
	task automatic wr(input logic [6:0] a, input logic [7:0] c,
		input logic [23:0] d, input int n);
		logic [2:0] p;
		p = c[2:0];
		u_i2c_master_model.start();
		send({a, 1'b0});
		send(c);
		for (int i = 0; i < n; i++) begin
			send(d[8*i +: 8]);
			// input pair never takes data
			if (a == adr_a && p > 3'h1) begin
				ex[p] = d[8*i +: 8];
			end
			p = p ^ 3'h1;
		end
		u_i2c_master_model.stop();
	endtask

	// command, repeated start, then two bytes into r0 and
	task automatic rd2(input logic [6:0] a, input logic [7:0] c);
		u_i2c_master_model.start();
		send({a, 1'b0});
		send(c);
		u_i2c_master_model.start();
		send({a, 1'b1});
		u_i2c_master_model.rbyte(1'b0, r0);
		u_i2c_master_model.rbyte(1'b1, r1);
		u_i2c_master_model.stop();
	endtask

	// verdict and end of run
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard, well above the expected 60k cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
			finish_test();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		void'($urandom(60));
		ex = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
		repeat (5) @(posedge clock);
		#3 arst_n = 1'b1;
		strap = 2'($urandom);
		repeat (20) @(posedge clock);
		// defaults after power-on
		chk_pins(a_o, 16'hFFFF);
		chk_pins(a_oe_n, 16'hFFFF);
		chk_byte({6'h00, sdo}, 8'h00);
		for (int c = 2; c < 8; c += 2) begin
			rd2(adr_a, 8'(c));
			chk_byte(r0, ex[c]);
			chk_byte(r1, ex[c+1]);
		end
		$display("defaults done");
		// three bytes per pair from a random start, then read back
		for (int p = 1; p < 4; p++) begin
			k = 2 * p + int'($urandom_range(1));
			wr(adr_a, 8'(k), 24'($urandom), 3);
			chk_pins(a_o, {ex[3], ex[2]});
			chk_pins(a_oe_n, {ex[7], ex[6]});
			rd2(adr_a, 8'(k ^ 1));
			chk_byte(r0, ex[k^1]);
			chk_byte(r1, ex[k]);
		end
		$display("writes done");
		// input pair: discarded writes, inversion, odd start
		@(posedge clock);
		#3 io_i = 16'($urandom);
		wr(adr_a, 8'h00, 24'($urandom), 2);
		chk_pins(a_o, {ex[3], ex[2]});
		chk_pins(a_oe_n, {ex[7], ex[6]});
		rd2(adr_a, 8'h01);
		chk_byte(r0, exp_rd(1));
		chk_byte(r1, exp_rd(0));
		$display("inputs done");
		// foreign addresses get no acknowledge
		for (int j = 0; j < 2; j++) begin
			u_i2c_master_model.start();
			u_i2c_master_model.wbyte({adr_a ^ (j ? 7'h20 : 7'h01), 1'b0}, ack);
			chk_byte({7'h00, ack}, 8'h01);
			u_i2c_master_model.stop();
		end
		$display("address done");
		// bus-only device gets outputs before the reset pulse
		wr(adr_b, 8'h06, 24'h00F00F, 2);
		wr(adr_b, 8'h02, 24'h00A53C, 2);
		@(posedge clock);
		#3 reset_pin_n = 1'b0;
		repeat (10) @(posedge clock);
		chk_pins(a_oe_n, 16'hFFFF);
		chk_pins(a_o, 16'hFFFF);
		chk_pins(b_o, 16'hA53C);
		chk_pins(b_oe_n, 16'hF00F);
		@(posedge clock);
		#3 reset_pin_n = 1'b1;
		repeat (20) @(posedge clock);
		rd2(adr_a, 8'h04);
		chk_byte(r0, 8'h00);
		chk_byte(r1, 8'h00);
		rd2(adr_b, 8'h02);
		chk_byte(r0, 8'h3C);
		chk_byte(r1, 8'hA5);
		$display("reset pin done");
		finish_test();
	end
endmodule
